/* File: rtcc_div.sv */
`timescale 1ns/1ps
module rtcc_div #(
    parameter int CLK_PER_TICK = rtcc_pkg::TICKS_PER_4096HZ
) (
    input wire logic clk_sys, // System clock.
    input wire logic srst, // Synchronous reset, active high.
    input wire logic hold, // Holds the sub-second stages cleared.
    output logic tick_4096, // One-cycle pulse at 4096 Hz.
    output logic tick_64, // One-cycle pulse at 64 Hz.
    output logic tick_1hz // One-cycle pulse once per second.
);

    localparam int PW = $clog2(CLK_PER_TICK);

    if (CLK_PER_TICK < 2)
    begin : g_chk
        $error("rtcc_div: CLK_PER_TICK must be at least 2");
    end

    typedef struct packed {
        logic [PW-1:0] presc;
        logic [rtcc_pkg::SUB_W-1:0] sub;
        logic t4096;
        logic t64;
        logic t1;
    } rtcc_div_st_t;

    rtcc_div_st_t s;
    rtcc_div_st_t next_s;

    // The prescaler keeps running while held, so the fastest source
    // stays alive; only the 2048 Hz to 1 Hz stages are cleared.
    always_comb
    begin
        next_s = s;
        next_s.t4096 = 1'b0;
        next_s.t64 = 1'b0;
        next_s.t1 = 1'b0;
        if (s.presc == PW'(CLK_PER_TICK - 1))
        begin
            next_s.presc = '0;
            next_s.t4096 = 1'b1;
            next_s.sub = s.sub + 1'b1;
            next_s.t64 = !hold && (&s.sub[rtcc_pkg::DIV64_W-1:0]);
            next_s.t1 = !hold && (&s.sub);
        end
        else
        begin
            next_s.presc = s.presc + 1'b1;
        end
        if (hold)
        begin
            next_s.sub = '0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign tick_4096 = s.t4096;
    assign tick_64 = s.t64;
    assign tick_1hz = s.t1;

endmodule : rtcc_div

/* File: rtcc_pkg.sv */
package rtcc_pkg;

    // ************************************************************
    // Register indices; the byte address is four times the index.
    // ************************************************************
    localparam logic [3:0] IDX_SEC = 4'h0;
    localparam logic [3:0] IDX_MIN = 4'h1;
    localparam logic [3:0] IDX_HOUR = 4'h2;
    localparam logic [3:0] IDX_WEEK = 4'h3;
    localparam logic [3:0] IDX_DATE = 4'h4;
    localparam logic [3:0] IDX_MONTH = 4'h5;
    localparam logic [3:0] IDX_YEAR = 4'h6;
    localparam logic [3:0] IDX_SCRATCH = 4'h7;
    localparam logic [3:0] IDX_EXT = 4'hd;
    localparam logic [3:0] IDX_CTRL = 4'hf;
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 5;

    // ************************************************************
    // Writable bit masks; the other bits read as zero.
    // ************************************************************
    localparam logic [7:0] MASK_SEC = 8'h7f;
    localparam logic [7:0] MASK_MIN = 8'h7f;
    localparam logic [7:0] MASK_HOUR = 8'h3f;
    localparam logic [7:0] MASK_WEEK = 8'h7f;
    localparam logic [7:0] MASK_DATE = 8'h3f;
    localparam logic [7:0] MASK_MONTH = 8'h1f;
    localparam logic [7:0] MASK_FULL = 8'hff;
    localparam int STOP_BIT = 1;

    // ************************************************************
    // Counter limits in packed BCD.
    // ************************************************************
    localparam logic [7:0] BCD_ZERO = 8'h00;
    localparam logic [7:0] BCD_ONE = 8'h01;
    localparam logic [7:0] SEC_LAST = 8'h59;
    localparam logic [7:0] MIN_LAST = 8'h59;
    localparam logic [7:0] HOUR_LAST = 8'h23;
    localparam logic [7:0] MONTH_LAST = 8'h12;
    localparam logic [7:0] YEAR_LAST = 8'h99;
    localparam logic [7:0] DAYS_LONG = 8'h31;
    localparam logic [7:0] DAYS_SHORT = 8'h30;
    localparam logic [7:0] DAYS_FEB = 8'h28;
    localparam logic [7:0] DAYS_FEB_LEAP = 8'h29;
    localparam logic [7:0] MON_FEB = 8'h02;
    localparam logic [7:0] MON_APR = 8'h04;
    localparam logic [7:0] MON_JUN = 8'h06;
    localparam logic [7:0] MON_SEP = 8'h09;
    localparam logic [7:0] MON_NOV = 8'h11;
    localparam logic [3:0] BCD_NINE = 4'h9;
    localparam logic [6:0] WEEK_FIRST = 7'h01;

    // ************************************************************
    // Reset values and timing.
    // ************************************************************
    localparam logic [7:0] RST_YEAR = 8'h01;
    localparam logic [7:0] RST_WEEK = 8'h01;
    localparam int CLK_HZ = 250_000_000;
    localparam int SRC_HZ = 4096;
    localparam int TICKS_PER_4096HZ = CLK_HZ / SRC_HZ;
    localparam int SUB_W = 12;
    localparam int DIV64_W = 6;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        RTCC_SRC_4096HZ = 2'b00,
        RTCC_SRC_64HZ = 2'b01,
        RTCC_SRC_SECOND = 2'b10,
        RTCC_SRC_MINUTE = 2'b11
    } rtcc_tsrc_t;

endpackage : rtcc_pkg

/* File: rtcc_top.sv */
// Functional notes
// - Two-bit select picks timer source tick.
// - Scratch byte stores any 8-bit value.
// - Unused register bits ignore writes, read zero.
// - Seconds, minutes, hours kept as packed BCD.
// - Seconds count 00 to 59, then 00.
// - Minutes count 00 to 59, then 00.
// - Hours count 00 to 23, then 00.
// - Weekday one-hot, rotates left, 40h to 01h.
// - Weekday codes Sunday 01h to Saturday 40h.
// - Calendar correct from 2001 through 2099.
// - Date, month, year kept as packed BCD.
// - Date wraps after 31, 30 or 28.
// - Year multiple of four: February reaches 29.
// - Month counts 01 to 12, then 01.
// - Year counts 00 to 99, then 00.
// - Stop holds counters and 2048 Hz to 1 Hz divider stages.
`timescale 1ns/1ps
module rtcc_top #(
    parameter int ADDR_W = 8,
    parameter int CLK_PER_TICK = rtcc_pkg::TICKS_PER_4096HZ
) (
    input wire logic clk_sys, // System clock, 250 MHz.
    input wire logic srst, // Synchronous reset, active high.
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address.
    input wire logic s_axi_awvalid, // Write address valid.
    output logic s_axi_awready, // Write address ready.
    input wire logic [31:0] s_axi_wdata, // Write data.
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
    input wire logic s_axi_wvalid, // Write data valid.
    output logic s_axi_wready, // Write data ready.
    output logic [1:0] s_axi_bresp, // Write response.
    output logic s_axi_bvalid, // Write response valid.
    input wire logic s_axi_bready, // Write response ready.
    input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address.
    input wire logic s_axi_arvalid, // Read address valid.
    output logic s_axi_arready, // Read address ready.
    output logic [31:0] s_axi_rdata, // Read data.
    output logic [1:0] s_axi_rresp, // Read response.
    output logic s_axi_rvalid, // Read data valid.
    input wire logic s_axi_rready, // Read data ready.
    output logic tmr_src_tick // Selected timer source pulse.
);

    if (ADDR_W < rtcc_pkg::IDX_MSB + 1)
    begin : g_chk
        $error("rtcc_top: ADDR_W too small for the register map");
    end

    // ************************************************************
    // State.
    // ************************************************************
    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_got;
        logic w_got;
        logic [3:0] widx;
        logic wbad;
        logic [7:0] wbyte;
        logic wlane;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] week;
        logic [7:0] date;
        logic [7:0] month;
        logic [7:0] year;
        logic [7:0] scratch;
        rtcc_pkg::rtcc_tsrc_t tsel;
        logic stop;
        logic src_tick;
    } rtcc_st_t;

    rtcc_st_t s;
    rtcc_st_t next_s;
    logic tick_4096;
    logic tick_64;
    logic tick_1hz;
    logic tick;
    logic wr_en;
    logic c_sec;
    logic c_min;
    logic c_hour;
    logic c_date;
    logic c_month;

    rtcc_div #(
        .CLK_PER_TICK(CLK_PER_TICK)
    ) u_div (
        .clk_sys(clk_sys),
        .srst(srst),
        .hold(s.stop),
        .tick_4096(tick_4096),
        .tick_64(tick_64),
        .tick_1hz(tick_1hz)
    );

    // ************************************************************
    // Helpers.
    // ************************************************************
    function automatic logic idx_ok(input logic [ADDR_W-1:0] a);
        logic [3:0] i;
        i = a[rtcc_pkg::IDX_MSB:rtcc_pkg::IDX_LSB];
        idx_ok = (a[1:0] == 2'b00) && (a >> (rtcc_pkg::IDX_MSB + 1)) == '0
            && (i <= rtcc_pkg::IDX_SCRATCH || i == rtcc_pkg::IDX_EXT
            || i == rtcc_pkg::IDX_CTRL);
    endfunction : idx_ok

    function automatic logic [7:0] bcd_inc(input logic [7:0] v,
        input logic [7:0] last, input logic [7:0] first);
        if (v == last)
        begin
            bcd_inc = first;
        end
        else if (v[3:0] == rtcc_pkg::BCD_NINE)
        begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        end
        else
        begin
            bcd_inc = v + 8'h01;
        end
    endfunction : bcd_inc

    function automatic logic is_leap(input logic [7:0] y);
        if (y[4])
        begin
            is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
        end
        else
        begin
            is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
        end
    endfunction : is_leap

    function automatic logic [7:0] last_day(input logic [7:0] m,
        input logic [7:0] y);
        case (m)
            rtcc_pkg::MON_FEB: last_day = is_leap(y) ? rtcc_pkg::DAYS_FEB_LEAP
                : rtcc_pkg::DAYS_FEB;
            rtcc_pkg::MON_APR,
            rtcc_pkg::MON_JUN,
            rtcc_pkg::MON_SEP,
            rtcc_pkg::MON_NOV: last_day = rtcc_pkg::DAYS_SHORT;
            default: last_day = rtcc_pkg::DAYS_LONG;
        endcase
    endfunction : last_day

    function automatic logic [7:0] rd_mux(input rtcc_st_t t, input logic [3:0] i);
        case (i)
            rtcc_pkg::IDX_SEC: rd_mux = t.sec;
            rtcc_pkg::IDX_MIN: rd_mux = t.min;
            rtcc_pkg::IDX_HOUR: rd_mux = t.hour;
            rtcc_pkg::IDX_WEEK: rd_mux = t.week;
            rtcc_pkg::IDX_DATE: rd_mux = t.date;
            rtcc_pkg::IDX_MONTH: rd_mux = t.month;
            rtcc_pkg::IDX_YEAR: rd_mux = t.year;
            rtcc_pkg::IDX_SCRATCH: rd_mux = t.scratch;
            rtcc_pkg::IDX_EXT: rd_mux = {6'h00, t.tsel};
            rtcc_pkg::IDX_CTRL: rd_mux = 8'(t.stop) << rtcc_pkg::STOP_BIT;
            default: rd_mux = 8'h00;
        endcase
    endfunction : rd_mux

    // ************************************************************
    // Next state.
    // ************************************************************
    always_comb
    begin
        next_s = s;
        tick = tick_1hz && !s.stop;
        c_sec = tick && (s.sec == rtcc_pkg::SEC_LAST);
        c_min = c_sec && (s.min == rtcc_pkg::MIN_LAST);
        c_hour = c_min && (s.hour == rtcc_pkg::HOUR_LAST);
        c_date = c_hour && (s.date == last_day(s.month, s.year));
        c_month = c_date && (s.month == rtcc_pkg::MONTH_LAST);
        wr_en = s.aw_got && s.w_got && !s.bvalid;

        if (tick)
        begin
            next_s.sec = bcd_inc(s.sec, rtcc_pkg::SEC_LAST, rtcc_pkg::BCD_ZERO);
        end
        if (c_sec)
        begin
            next_s.min = bcd_inc(s.min, rtcc_pkg::MIN_LAST, rtcc_pkg::BCD_ZERO);
        end
        if (c_min)
        begin
            next_s.hour = bcd_inc(s.hour, rtcc_pkg::HOUR_LAST, rtcc_pkg::BCD_ZERO);
        end
        if (c_hour)
        begin
            next_s.week = {1'b0, s.week[5:0], s.week[6]};
            next_s.date = bcd_inc(s.date, last_day(s.month, s.year),
                rtcc_pkg::BCD_ONE);
        end
        if (c_date)
        begin
            next_s.month = bcd_inc(s.month, rtcc_pkg::MONTH_LAST, rtcc_pkg::BCD_ONE);
        end
        if (c_month)
        begin
            next_s.year = bcd_inc(s.year, rtcc_pkg::YEAR_LAST, rtcc_pkg::BCD_ZERO);
        end

        case (s.tsel)
            rtcc_pkg::RTCC_SRC_4096HZ: next_s.src_tick = tick_4096;
            rtcc_pkg::RTCC_SRC_64HZ: next_s.src_tick = tick_64;
            rtcc_pkg::RTCC_SRC_SECOND: next_s.src_tick = tick;
            rtcc_pkg::RTCC_SRC_MINUTE: next_s.src_tick = c_sec;
            default: next_s.src_tick = 1'b0;
        endcase

        // Address and data are taken in either order and held.
        if (s.awready && s_axi_awvalid)
        begin
            next_s.aw_got = 1'b1;
            next_s.widx = s_axi_awaddr[rtcc_pkg::IDX_MSB:rtcc_pkg::IDX_LSB];
            next_s.wbad = !idx_ok(s_axi_awaddr);
        end
        if (s.wready && s_axi_wvalid)
        begin
            next_s.w_got = 1'b1;
            next_s.wbyte = s_axi_wdata[7:0];
            next_s.wlane = s_axi_wstrb[0];
        end
        // A software write overrides the count step of that register.
        if (wr_en)
        begin
            next_s.aw_got = 1'b0;
            next_s.w_got = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = s.wbad ? rtcc_pkg::RESP_SLVERR : rtcc_pkg::RESP_OKAY;
            if (!s.wbad && s.wlane)
            begin
                case (s.widx)
                    rtcc_pkg::IDX_SEC: next_s.sec = s.wbyte & rtcc_pkg::MASK_SEC;
                    rtcc_pkg::IDX_MIN: next_s.min = s.wbyte & rtcc_pkg::MASK_MIN;
                    rtcc_pkg::IDX_HOUR: next_s.hour = s.wbyte & rtcc_pkg::MASK_HOUR;
                    rtcc_pkg::IDX_WEEK: next_s.week = s.wbyte & rtcc_pkg::MASK_WEEK;
                    rtcc_pkg::IDX_DATE: next_s.date = s.wbyte & rtcc_pkg::MASK_DATE;
                    rtcc_pkg::IDX_MONTH: next_s.month = s.wbyte & rtcc_pkg::MASK_MONTH;
                    rtcc_pkg::IDX_YEAR: next_s.year = s.wbyte & rtcc_pkg::MASK_FULL;
                    rtcc_pkg::IDX_SCRATCH: next_s.scratch = s.wbyte;
                    rtcc_pkg::IDX_EXT: next_s.tsel = rtcc_pkg::rtcc_tsrc_t'(s.wbyte[1:0]);
                    rtcc_pkg::IDX_CTRL: next_s.stop = s.wbyte[rtcc_pkg::STOP_BIT];
                    default: next_s.stop = s.stop;
                endcase
            end
        end
        if (s.bvalid && s_axi_bready)
        begin
            next_s.bvalid = 1'b0;
        end
        next_s.awready = !next_s.aw_got && !next_s.bvalid;
        next_s.wready = !next_s.w_got && !next_s.bvalid;

        // Reads answer one cycle after the address is taken.
        if (s.arready && s_axi_arvalid)
        begin
            next_s.rvalid = 1'b1;
            if (idx_ok(s_axi_araddr))
            begin
                next_s.rdata = rd_mux(s,
                    s_axi_araddr[rtcc_pkg::IDX_MSB:rtcc_pkg::IDX_LSB]);
                next_s.rresp = rtcc_pkg::RESP_OKAY;
            end
            else
            begin
                next_s.rdata = 8'h00;
                next_s.rresp = rtcc_pkg::RESP_SLVERR;
            end
        end
        else if (s.rvalid && s_axi_rready)
        begin
            next_s.rvalid = 1'b0;
        end
        next_s.arready = !next_s.rvalid;
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            s <= '0;
            s.week <= rtcc_pkg::RST_WEEK;
            s.date <= rtcc_pkg::BCD_ONE;
            s.month <= rtcc_pkg::BCD_ONE;
            s.year <= rtcc_pkg::RST_YEAR;
            s.tsel <= rtcc_pkg::RTCC_SRC_4096HZ;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = s.arready;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = {24'h00_0000, s.rdata};
    assign s_axi_rresp = s.rresp;
    assign tmr_src_tick = s.src_tick;

    // ************************************************************
    // Assertions.
    // ************************************************************
    sequence sq_sec_wrap;
        tick && !wr_en && s.sec == rtcc_pkg::SEC_LAST;
    endsequence

    sequence sq_min_wrap;
        sq_sec_wrap ##0 s.min == rtcc_pkg::MIN_LAST;
    endsequence

    property p_tsel_fast;
        @(posedge clk_sys) disable iff (srst)
        s.tsel == rtcc_pkg::RTCC_SRC_4096HZ && !wr_en && tick_4096 |=> tmr_src_tick;
    endproperty
    a_tsel_fast: assert property (p_tsel_fast) else $error("4096 Hz source missed");

    property p_scratch;
        @(posedge clk_sys) disable iff (srst)
        wr_en && !s.wbad && s.wlane && s.widx == rtcc_pkg::IDX_SCRATCH
        |=> s.scratch == $past(s.wbyte) ##1 s_axi_bvalid || $past(s_axi_bready);
    endproperty
    a_scratch: assert property (p_scratch) else $error("scratch byte lost");

    property p_unused_zero;
        @(posedge clk_sys) disable iff (srst)
        !s.sec[7] && !s.min[7] && s.hour[7:6] == 2'b00 && !s.week[7]
        && s.date[7:6] == 2'b00 && s.month[7:5] == 3'b000;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused bit set");

    property p_sec_wrap;
        @(posedge clk_sys) disable iff (srst)
        sq_sec_wrap |=> s.sec == rtcc_pkg::BCD_ZERO && s.min != $past(s.min);
    endproperty
    a_sec_wrap: assert property (p_sec_wrap) else $error("seconds wrap wrong");

    property p_min_wrap;
        @(posedge clk_sys) disable iff (srst)
        sq_min_wrap |=> s.min == rtcc_pkg::BCD_ZERO && s.hour != $past(s.hour);
    endproperty
    a_min_wrap: assert property (p_min_wrap) else $error("minutes wrap wrong");

    property p_hour_wrap;
        @(posedge clk_sys) disable iff (srst)
        sq_min_wrap ##0 s.hour == rtcc_pkg::HOUR_LAST
        |=> s.hour == rtcc_pkg::BCD_ZERO && s.week != $past(s.week);
    endproperty
    a_hour_wrap: assert property (p_hour_wrap) else $error("hours wrap wrong");

    property p_week_rot;
        @(posedge clk_sys) disable iff (srst)
        c_hour && !wr_en && s.week == 8'h40 |=> s.week == 8'h01;
    endproperty
    a_week_rot: assert property (p_week_rot) else $error("weekday wrap wrong");

    property p_feb_leap;
        @(posedge clk_sys) disable iff (srst)
        c_hour && !wr_en && s.month == rtcc_pkg::MON_FEB && is_leap(s.year)
        && s.date == rtcc_pkg::DAYS_FEB |=> s.date == rtcc_pkg::DAYS_FEB_LEAP;
    endproperty
    a_feb_leap: assert property (p_feb_leap) else $error("leap day skipped");

    property p_year_wrap;
        @(posedge clk_sys) disable iff (srst)
        c_month && !wr_en && s.year == rtcc_pkg::YEAR_LAST
        |=> s.year == rtcc_pkg::BCD_ZERO && s.month == rtcc_pkg::BCD_ONE;
    endproperty
    a_year_wrap: assert property (p_year_wrap) else $error("year wrap wrong");

    property p_stop_hold;
        @(posedge clk_sys) disable iff (srst)
        s.stop && !wr_en |=> $stable(s.sec) && $stable(s.date) && !tick_1hz;
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("stopped clock moved");

endmodule : rtcc_top

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    // ************************************************************
    // Clock, reset and design hookup.
    // ************************************************************
    // A short prescale keeps one counted second at 16384 clocks.
    localparam int TICK_CLKS = 4;
    localparam int SECOND_CLKS = 4096 * TICK_CLKS;
    localparam int LIMIT = 100000;
    localparam logic [7:0] RST_VAL [8] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h01, 8'h00};
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic tmr_src_tick;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;

    always #2 clk_sys = ~clk_sys;

    rtcc_top #(.ADDR_W(8), .CLK_PER_TICK(TICK_CLKS)) i_rtcc_top (
        .clk_sys(clk_sys), .srst(srst), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .tmr_src_tick(tmr_src_tick));

    // ************************************************************
    // Bus tasks and comparison.
    // ************************************************************
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked = samples_checked + 1;
        if (got !== exp)
        begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Each channel is released only at the edge where its own ready was seen.
    task automatic wr(input logic [3:0] idx, input logic [7:0] d, output logic [1:0] resp);
        logic aw_left;
        logic w_left;
        aw_left = 1'b1;
        w_left = 1'b1;
        s_axi_awaddr <= {2'b00, idx, 2'b00};
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_wstrb <= 4'h1;
        s_axi_wvalid <= 1'b1;
        while (aw_left || w_left)
        begin
            @(posedge clk_sys);
            if (aw_left && s_axi_awready === 1'b1)
            begin
                aw_left = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w_left && s_axi_wready === 1'b1)
            begin
                w_left = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b1;
        do
            @(posedge clk_sys);
        while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] idx, output logic [31:0] d, output logic [1:0] resp);
        s_axi_araddr <= {2'b00, idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        do
            @(posedge clk_sys);
        while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do
            @(posedge clk_sys);
        while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd

    task automatic rd_chk(input logic [3:0] idx, input logic [7:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(idx, d, r);
        chk(d, {24'h00_0000, e});
        chk({30'h0, r}, {30'h0, rtcc_pkg::RESP_OKAY});
    endtask : rd_chk

    task automatic wr_rd(input logic [3:0] idx, input logic [7:0] d, input logic [7:0] e);
        logic [1:0] r;
        wr(idx, d, r);
        chk({30'h0, r}, {30'h0, rtcc_pkg::RESP_OKAY});
        rd_chk(idx, e);
    endtask : wr_rd

    task automatic count_ticks(input int span, input int n);
        int seen;
        seen = 0;
        repeat (span)
        begin
            @(posedge clk_sys);
            if (tmr_src_tick === 1'b1)
                seen = seen + 1;
        end
        chk(seen, n);
    endtask : count_ticks

    // Loads 23:59:59 with the counters stopped, so no second lands mid-setup.
    task automatic roll(input logic [7:0] wk, dt, mo, yr, ewk, edt, emo, eyr);
        logic [1:0] r;
        wr(rtcc_pkg::IDX_CTRL, 8'h01 << rtcc_pkg::STOP_BIT, r);
        wr(rtcc_pkg::IDX_SEC, 8'h59, r);
        wr(rtcc_pkg::IDX_MIN, 8'h59, r);
        wr(rtcc_pkg::IDX_HOUR, 8'h23, r);
        wr(rtcc_pkg::IDX_WEEK, wk, r);
        wr(rtcc_pkg::IDX_DATE, dt, r);
        wr(rtcc_pkg::IDX_MONTH, mo, r);
        wr(rtcc_pkg::IDX_YEAR, yr, r);
        wr(rtcc_pkg::IDX_CTRL, 8'h00, r);
        count_ticks(SECOND_CLKS + 600, 1);
        rd_chk(rtcc_pkg::IDX_SEC, 8'h00);
        rd_chk(rtcc_pkg::IDX_MIN, 8'h00);
        rd_chk(rtcc_pkg::IDX_HOUR, 8'h00);
        rd_chk(rtcc_pkg::IDX_WEEK, ewk);
        rd_chk(rtcc_pkg::IDX_DATE, edt);
        rd_chk(rtcc_pkg::IDX_MONTH, emo);
        rd_chk(rtcc_pkg::IDX_YEAR, eyr);
    endtask : roll

    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            num_errors = num_errors + 1;
            wrap_up();
        end
    end

    // ************************************************************
    // Test sequence.
    // ************************************************************
    initial
    begin
        logic [31:0] d;
        logic [1:0] r;
        repeat (16) @(posedge clk_sys);
        srst <= 1'b0;
        for (int i = 0; i < 8; i++)
            rd_chk(i[3:0], RST_VAL[i]);
        count_ticks(400, 100);
        wr_rd(rtcc_pkg::IDX_SCRATCH, 8'hff, 8'hff);
        wr_rd(rtcc_pkg::IDX_SCRATCH, 8'ha5, 8'ha5);
        wr(rtcc_pkg::IDX_CTRL, 8'h01 << rtcc_pkg::STOP_BIT, r);
        wr_rd(rtcc_pkg::IDX_SEC, 8'hff, rtcc_pkg::MASK_SEC);
        wr_rd(rtcc_pkg::IDX_MIN, 8'hff, rtcc_pkg::MASK_MIN);
        wr_rd(rtcc_pkg::IDX_HOUR, 8'hff, rtcc_pkg::MASK_HOUR);
        wr_rd(rtcc_pkg::IDX_DATE, 8'hff, rtcc_pkg::MASK_DATE);
        wr_rd(rtcc_pkg::IDX_MONTH, 8'hff, rtcc_pkg::MASK_MONTH);
        for (int i = 0; i < 7; i++)
            wr_rd(rtcc_pkg::IDX_WEEK, 8'h01 << i, 8'h01 << i);
        for (int i = 3; i >= 0; i--)
            wr_rd(rtcc_pkg::IDX_EXT, i[7:0], i[7:0]);
        count_ticks(400, 100);
        wr(rtcc_pkg::IDX_EXT, 8'h01, r);
        count_ticks(400, 0);
        wr_rd(rtcc_pkg::IDX_SEC, 8'h42, 8'h42);
        count_ticks(SECOND_CLKS + 600, 0);
        rd_chk(rtcc_pkg::IDX_SEC, 8'h42);
        rd(4'h8, d, r);
        chk({30'h0, r}, {30'h0, rtcc_pkg::RESP_SLVERR});
        chk(d, 32'h0000_0000);
        wr(4'h8, 8'h11, r);
        chk({30'h0, r}, {30'h0, rtcc_pkg::RESP_SLVERR});
        // The minute source pulses once on each rolled-over minute.
        wr(rtcc_pkg::IDX_EXT, 8'h03, r);
        roll(8'h40, 8'h28, 8'h02, 8'h04, 8'h01, 8'h29, 8'h02, 8'h04);
        roll(8'h01, 8'h28, 8'h02, 8'h05, 8'h02, 8'h01, 8'h03, 8'h05);
        wr(rtcc_pkg::IDX_EXT, 8'h02, r);
        roll(8'h08, 8'h30, 8'h04, 8'h98, 8'h10, 8'h01, 8'h05, 8'h98);
        roll(8'h20, 8'h31, 8'h12, 8'h99, 8'h40, 8'h01, 8'h01, 8'h00);
        wr(rtcc_pkg::IDX_EXT, 8'h01, r);
        count_ticks(512, 2);
        rd_chk(rtcc_pkg::IDX_SCRATCH, 8'ha5);
        wrap_up();
    end
endmodule : tb_top
